// ---- rtl/twsr_pkg.sv ----
// Shared constants of the thermal watchdog and its two-wire register port.
// Assumes a single 20 MHz system clock; every bus line is sampled by it.
package twsr_pkg;

  // Fixed upper nibble of the 7-bit slave address.
  localparam logic [3:0] TWSR_ADDR_HI = 4'h9;

  // Register selector codes.
  localparam logic [1:0] TWSR_SEL_TEMP = 2'h0;
  localparam logic [1:0] TWSR_SEL_CFG = 2'h1;
  localparam logic [1:0] TWSR_SEL_REL = 2'h2;
  localparam logic [1:0] TWSR_SEL_TRIP = 2'h3;
  localparam logic [1:0] TWSR_SEL_RESET = 2'h0;

  // Configuration field positions and reset value.
  localparam int TWSR_CFG_SHUT = 0;
  localparam int TWSR_CFG_INTM = 1;
  localparam int TWSR_CFG_POL = 2;
  localparam int TWSR_CFG_FQ_LO = 3;
  localparam int TWSR_CFG_FQ_HI = 4;
  localparam logic [7:0] TWSR_CFG_RESET = 8'h00;

  // Fault queue depths selected by the two-bit field.
  localparam logic [2:0] TWSR_FQ_1 = 3'h1;
  localparam logic [2:0] TWSR_FQ_2 = 3'h2;
  localparam logic [2:0] TWSR_FQ_4 = 3'h4;
  localparam logic [2:0] TWSR_FQ_6 = 3'h6;

  // Byte framing: bits per byte and index of the last tracked byte.
  localparam logic [3:0] TWSR_BYTE_BITS = 4'h8;
  localparam logic [1:0] TWSR_IDX_MAX = 2'h3;
  localparam logic [1:0] TWSR_IDX_PTR = 2'h0;
  localparam logic [1:0] TWSR_IDX_MSB = 2'h1;
  localparam logic [1:0] TWSR_IDX_LSB = 2'h2;

  // Reset value of the temperature reading.
  localparam logic [8:0] TWSR_TEMP_RESET = 9'h000;

  // Bus engine states, Gray coded along address, ack, data.
  typedef enum logic [2:0] {
    TWSR_IDLE = 3'b000,
    TWSR_ADDR = 3'b001,
    TWSR_SACK = 3'b011,
    TWSR_RX = 3'b010,
    TWSR_TX = 3'b110,
    TWSR_MACK = 3'b111
  } twsr_state_t;

endpackage

// ---- rtl/twsr_top.sv ----
// Thermal watchdog with a two-wire slave register port and an open-drain alarm.
// Assumes bus lines and address pins are asynchronous to clk; the converter
// result arrives on clk with a one-cycle valid pulse.
`timescale 1ns/10ps
module twsr_top import twsr_pkg::*; #(
  parameter logic [8:0] TRIP_RESET = 9'h0a0,
  parameter logic [8:0] RELEASE_RESET = 9'h096
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Two-wire bus pins
  input wire logic bus_clock_pin,
  input wire logic bus_data_pin_i,
  output logic bus_data_pin_o,
  output logic bus_data_pin_oe,
  // Address straps
  input wire logic [2:0] addr_select_pins,
  // Converter result
  input wire logic conv_valid,
  input wire logic [8:0] conv_temp,
  // Alarm pin, open-drain
  input wire logic alarm_pin_i,
  output logic alarm_pin_o,
  output logic alarm_pin_oe,
  // Power state for the converter
  output logic shutdown_active
);

  // Fault queue depth from the configuration field.
  function automatic logic [2:0] fq_need(input logic [1:0] code);
    case (code)
      2'h0: fq_need = TWSR_FQ_1;
      2'h1: fq_need = TWSR_FQ_2;
      2'h2: fq_need = TWSR_FQ_4;
      default: fq_need = TWSR_FQ_6;
    endcase
  endfunction

  // Place a 9-bit value in the upper bits of a 16-bit word, low bits zero.
  function automatic logic [15:0] word16(input logic [8:0] v);
    word16 = {v, 7'h00};
  endfunction

  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic [2:0] addr_s1_reg;
  logic [2:0] addr_s2_reg;
  twsr_state_t state_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic [1:0] idx_reg;
  logic rw_reg;
  logic nack_reg;
  logic sda_oe_reg;
  logic [1:0] sel_reg;
  logic [7:0] cfg_reg;
  logic [8:0] trip_reg;
  logic [8:0] rel_reg;
  logic [8:0] temp_reg;
  logic [2:0] fault_cnt_reg;
  logic seek_low_reg;
  logic alarm_reg;
  logic os_oe_reg;

  // Synchronisers: stage 0 feeds only stage 1; stage 2 is the edge history.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      addr_s1_reg <= 3'h0;
      addr_s2_reg <= 3'h0;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], bus_clock_pin};
      sda_s_reg <= {sda_s_reg[1:0], bus_data_pin_i};
      addr_s1_reg <= addr_select_pins;
      addr_s2_reg <= addr_s1_reg;
    end
  end

  // Line events seen by the bus engine.
  wire scl_rise = scl_s_reg[1] & ~scl_s_reg[2];
  wire scl_fall = ~scl_s_reg[1] & scl_s_reg[2];
  wire scl_high = scl_s_reg[1] & scl_s_reg[2];
  wire sda_now = sda_s_reg[1];
  wire bus_start = scl_high & ~sda_s_reg[1] & sda_s_reg[2];
  wire bus_stop = scl_high & sda_s_reg[1] & ~sda_s_reg[2];
  wire byte_full = (cnt_reg == TWSR_BYTE_BITS);

  wire addr_match = (sh_reg[7:1] == {TWSR_ADDR_HI, addr_s2_reg});

  // A read transaction addressed to this device clears a latched alarm.
  wire rd_clear = (state_reg == TWSR_ADDR) & scl_fall & byte_full & addr_match & sh_reg[0];

  // Received byte strobes, decoded by position in the write.
  wire byte_done = (state_reg == TWSR_RX) & scl_fall & byte_full;
  wire wr_ptr = byte_done & (idx_reg == TWSR_IDX_PTR);
  wire wr_cfg = byte_done & (idx_reg == TWSR_IDX_MSB) & (sel_reg == TWSR_SEL_CFG);
  wire wr_hi = byte_done & (idx_reg == TWSR_IDX_MSB) & sel_reg[1];
  wire wr_lo = byte_done & (idx_reg == TWSR_IDX_LSB) & sel_reg[1];
  wire sel_trip = (sel_reg == TWSR_SEL_TRIP);

  // limits read back in bits 15..7
  wire [15:0] sel_word = (sel_reg == TWSR_SEL_TEMP) ? word16(temp_reg) :
                         (sel_reg == TWSR_SEL_REL) ? word16(rel_reg) :
                         (sel_reg == TWSR_SEL_TRIP) ? word16(trip_reg) :
                         {cfg_reg, cfg_reg};
  wire [7:0] tx_byte = (idx_reg == TWSR_IDX_PTR) ? sel_word[15:8] : sel_word[7:0];
  wire [1:0] idx_inc = (idx_reg == TWSR_IDX_MAX) ? idx_reg : idx_reg + 2'h1;

  // Bus engine. Start and stop win over any bit activity; a stop always
  // releases the data line. A stuck short read recovers by clocking out its byte.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= TWSR_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      idx_reg <= 2'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg <= TWSR_ADDR;
      cnt_reg <= 4'h0;
      idx_reg <= 2'h0;
      sda_oe_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= TWSR_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        TWSR_ADDR: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_now};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            rw_reg <= sh_reg[0];
            sda_oe_reg <= addr_match;
            state_reg <= addr_match ? TWSR_SACK : TWSR_IDLE;
          end
        end
        TWSR_SACK: begin
          if (scl_fall) begin
            // first bit is the byte's MSB
            if (rw_reg) begin
              sda_oe_reg <= ~tx_byte[7];
              sh_reg <= {tx_byte[6:0], 1'b0};
              cnt_reg <= 4'h1;
              state_reg <= TWSR_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= TWSR_RX;
            end
          end
        end
        TWSR_RX: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_now};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            sda_oe_reg <= 1'b1;
            idx_reg <= idx_inc;
            state_reg <= TWSR_SACK;
          end
        end
        TWSR_TX: begin
          if (scl_fall) begin
            if (byte_full) begin
              sda_oe_reg <= 1'b0;
              idx_reg <= idx_inc;
              state_reg <= TWSR_MACK;
            end else begin
              sda_oe_reg <= ~sh_reg[7];
              sh_reg <= {sh_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        TWSR_MACK: begin
          if (scl_rise) begin
            nack_reg <= sda_now;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_reg <= TWSR_IDLE;
            end else begin
              sda_oe_reg <= ~tx_byte[7];
              sh_reg <= {tx_byte[6:0], 1'b0};
              cnt_reg <= 4'h1;
              state_reg <= TWSR_TX;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Register file. Limit high bits land with the first data byte, the low
  // bit with the second, so a one-byte write still moves the limit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= TWSR_SEL_RESET;
      cfg_reg <= TWSR_CFG_RESET;
      trip_reg <= TRIP_RESET;
      rel_reg <= RELEASE_RESET;
    end else begin
      if (wr_ptr) begin
        sel_reg <= sh_reg[1:0];
      end
      if (wr_cfg) begin
        cfg_reg <= sh_reg;
      end
      if (wr_hi && sel_trip) begin
        trip_reg <= {sh_reg, trip_reg[0]};
      end
      if (wr_hi && !sel_trip) begin
        rel_reg <= {sh_reg, rel_reg[0]};
      end
      if (wr_lo && sel_trip) begin
        trip_reg[0] <= sh_reg[7];
      end
      if (wr_lo && !sel_trip) begin
        rel_reg[0] <= sh_reg[7];
      end
    end
  end

  // Configuration fields.
  wire cfg_shut = cfg_reg[TWSR_CFG_SHUT];
  wire cfg_intm = cfg_reg[TWSR_CFG_INTM];
  wire cfg_pol = cfg_reg[TWSR_CFG_POL];
  wire [2:0] need = fq_need(cfg_reg[TWSR_CFG_FQ_HI:TWSR_CFG_FQ_LO]);

  // Conversions are ignored while shut down, so the queue freezes too.
  wire conv_take = conv_valid & ~cfg_shut;
  wire over_trip = $signed(conv_temp) > $signed(trip_reg);
  wire under_rel = $signed(conv_temp) < $signed(rel_reg);
  wire fault = seek_low_reg ? under_rel : over_trip;
  wire [2:0] fault_inc = fault_cnt_reg + 3'h1;
  wire alarm_event = conv_take & fault & (fault_inc >= need);
  wire alarm_clear = cfg_intm & (rd_clear | cfg_shut);

  // Temperature capture and fault queue.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_reg <= TWSR_TEMP_RESET;
      fault_cnt_reg <= 3'h0;
    end else if (conv_take) begin
      temp_reg <= conv_temp;
      fault_cnt_reg <= (fault && !alarm_event) ? fault_inc : 3'h0;
    end
  end

  // Alarm state. The direction flips on every event, so comparator mode
  // gets hysteresis and interrupt mode alternates trip and release events.
  // An event in the same cycle as a clear wins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seek_low_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end else begin
      // next event from the other limit
      if (alarm_event) begin
        seek_low_reg <= ~seek_low_reg;
      end
      if (alarm_event) begin
        alarm_reg <= cfg_intm ? 1'b1 : ~seek_low_reg;
      end else if (alarm_clear) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  // polarity; pin only ever pulled low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      os_oe_reg <= 1'b0;
    end else begin
      os_oe_reg <= alarm_reg ^ cfg_pol;
    end
  end

  // Pin drivers: open-drain lines only ever drive low.
  assign bus_data_pin_o = 1'b0;
  assign bus_data_pin_oe = sda_oe_reg;
  assign alarm_pin_o = 1'b0;
  assign alarm_pin_oe = os_oe_reg;
  assign shutdown_active = cfg_shut;

endmodule

// ---- verif/twsr_sva.sv ----
// Pin-level checks for the thermal watchdog register port.
// Assumes one clk domain that samples the bus clock as a plain input.
`timescale 1ns/10ps
module twsr_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bus pins
  input wire logic bus_clock_pin,
  input wire logic bus_data_pin_i,
  input wire logic bus_data_pin_o,
  input wire logic bus_data_pin_oe,
  // Converter and alarm
  input wire logic conv_valid,
  input wire logic alarm_pin_o,
  input wire logic alarm_pin_oe,
  input wire logic shutdown_active
);
  // Every check runs on clk and rests during reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  pins_od_a: assert property (!alarm_pin_o && !bus_data_pin_o)
    else $error("open drain pin driven high");
  rst_quiet_a: assert property ($rose(arst_n) |->
    !shutdown_active && !alarm_pin_oe && !bus_data_pin_oe)
    else $error("outputs active after reset");
  oe_low_a: assert property ($changed(bus_data_pin_oe) |->
    !bus_clock_pin && !$past(bus_clock_pin))
    else $error("data changed while bus clock high");
  bit_hold_a: assert property ($rose(bus_data_pin_oe) |-> bus_data_pin_oe [*6])
    else $error("driven bit released early");
  stop_quiet_a: assert property (bus_clock_pin && $rose(bus_data_pin_i) |=>
    !bus_data_pin_oe [*8])
    else $error("data held after stop");
  alarm_cause_a: assert property ($changed(alarm_pin_oe) |->
    $past(conv_valid, 2) || !($past(bus_clock_pin, 3) && $past(bus_clock_pin, 5)))
    else $error("alarm changed without cause");
  shut_bus_a: assert property ($changed(shutdown_active) |->
    !($past(bus_clock_pin, 2) && $past(bus_clock_pin, 4)))
    else $error("shutdown changed outside a write");
  shut_frz_a: assert property (shutdown_active && $past(shutdown_active, 3) &&
    conv_valid && bus_clock_pin |-> ##2 $stable(alarm_pin_oe))
    else $error("alarm moved in shutdown");
endmodule

bind twsr_top twsr_sva u_sva (.clk(clk), .arst_n(arst_n),
  .bus_clock_pin(bus_clock_pin), .bus_data_pin_i(bus_data_pin_i),
  .bus_data_pin_o(bus_data_pin_o), .bus_data_pin_oe(bus_data_pin_oe),
  .conv_valid(conv_valid), .alarm_pin_o(alarm_pin_o),
  .alarm_pin_oe(alarm_pin_oe), .shutdown_active(shutdown_active));

// ---- verif/twsr_master.sv ----
// Bus master model: drives the bus clock and pulls the data wire low.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/10ps
module twsr_master (
  // Pacing clock
  input wire logic clk,
  // Bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Set when a stuck data line survives every recovery clock.
  logic hung = 1'b0;

  // The bus idles released with its clock high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // A quarter bit is two clocks, so one bit lasts 400 ns.
  task automatic q(input int n);
    repeat (2 * n) @(negedge clk);
  endtask

  task automatic start();
    sda_low = 1'b0;
    q(2);
    scl = 1'b1;
    q(2);
    sda_low = 1'b1;
    q(2);
    scl = 1'b0;
  endtask

  // Data moves only mid-low, so it never mimics a start or stop.
  task automatic tick(input logic b, output logic r);
    q(1);
    sda_low = !b;
    q(1);
    scl = 1'b1;
    q(1);
    r = sda;
    q(1);
    scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) tick(d[i], r);
    tick(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) tick(1'b1, d[i]);
    tick(nack, r);
  endtask

  task automatic stop();
    logic r;
    q(2);
    // The slave moves its bit a few clocks after our falling edge, so each
    // check waits that out; an early look could miss a low bit still coming.
    for (int i = 0; i < 10 && !sda; i++) begin
      tick(1'b1, r);
      q(2);
    end
    if (!sda) hung = 1'b1;
    q(1);
    sda_low = 1'b1;
    q(1);
    scl = 1'b1;
    q(2);
    sda_low = 1'b0;
    q(2);
  endtask
endmodule

// ---- verif/thermal_watchdog_smbus_regs_test.sv ----
// Self-checking bench for the thermal watchdog and its register port.
// Assumes the master model and the bound pin checker.
`timescale 1ns/10ps
module thermal_watchdog_smbus_regs_test import twsr_pkg::*;;
  localparam logic [8:0] TRIP0 = 9'h0a0;
  localparam logic [8:0] REL0 = 9'h096;
  localparam logic [8:0] TRIP1 = 9'h0c8;
  localparam logic [8:0] REL1 = 9'h0bf;
  localparam logic [8:0] ROOM = 9'h032;
  localparam logic [8:0] HOT = 9'h0d0;
  localparam logic [8:0] MID = 9'h0c0;
  localparam logic [8:0] COLD = 9'h1ce;
  logic clk;
  logic arst_n;
  logic scl;
  logic sda_low;
  logic conv_valid;
  logic [8:0] conv_temp;
  logic [2:0] strap;
  logic data_oe;
  logic alarm_oe;
  logic shut;
  logic [15:0] v;
  logic [6:0] adr;
  logic a;
  int n;
  int mismatches;
  int checked;
  wire sda;
  wire alarm;

  // Both wires have pull-ups; any party may pull them low.
  assign sda = !(sda_low || data_oe);
  assign alarm = !alarm_oe;

  twsr_top #(.TRIP_RESET(TRIP0), .RELEASE_RESET(REL0)) dut (.clk(clk), .arst_n(arst_n),
    .bus_clock_pin(scl), .bus_data_pin_i(sda), .bus_data_pin_o(), .bus_data_pin_oe(data_oe),
    .addr_select_pins(strap), .conv_valid(conv_valid), .conv_temp(conv_temp),
    .alarm_pin_i(alarm), .alarm_pin_o(), .alarm_pin_oe(alarm_oe), .shutdown_active(shut));
  twsr_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // Verdict and end of run.
  task automatic close_out();
    if (m.hung) mismatches++;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare and count.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Alarm pull-down against its expected state.
  task automatic al(input logic e);
    chk({15'h0000, alarm_oe}, {15'h0000, e});
  endtask

  // Write: address, selector, then n data bytes high first; all acked.
  task automatic wr(input logic [1:0] sel, input int n, input logic [15:0] d);
    logic ok;
    logic k;
    m.start();
    m.wbyte({adr, 1'b0}, ok);
    m.wbyte({6'h00, sel}, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) begin
      m.wbyte(i == 0 ? d[15:8] : d[7:0], k);
      ok = ok & k;
    end
    m.stop();
    chk({15'h0000, ok}, 16'h0001);
  endtask

  // Read one or two bytes, setting the selector first when asked.
  task automatic rd(input logic setp, input logic [1:0] sel, input logic two,
      input logic nack, output logic [15:0] r);
    logic k;
    logic [7:0] hi;
    logic [7:0] lo;
    lo = 8'h00;
    if (setp) begin
      m.start();
      m.wbyte({adr, 1'b0}, k);
      m.wbyte({6'h00, sel}, k);
    end
    m.start();
    m.wbyte({adr, 1'b1}, k);
    m.rbyte(nack && !two, hi);
    if (two) m.rbyte(nack, lo);
    m.stop();
    r = {hi, lo};
  endtask

  // Readings back to back, then time for the alarm pin to settle.
  task automatic feed(input logic [8:0] t, input int n);
    repeat (n) begin
      @(negedge clk);
      conv_temp = t;
      conv_valid = 1'b1;
    end
    @(negedge clk);
    conv_valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end

  // A hang counts as a failure.
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    conv_valid = 1'b0;
    conv_temp = 9'h000;
    strap = 3'h5;
    adr = {TWSR_ADDR_HI, 3'h5};
    mismatches = 0;
    checked = 0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    // A reading below trip makes the temperature register differ from config.
    feed(ROOM, 1);
    rd(1'b0, 2'h0, 1'b1, 1'b1, v);
    chk(v, {ROOM, 7'h00});
    rd(1'b1, TWSR_SEL_CFG, 1'b0, 1'b1, v);
    chk(v, 16'h0000);
    rd(1'b1, TWSR_SEL_TRIP, 1'b1, 1'b1, v);
    chk(v, {TRIP0, 7'h00});
    rd(1'b1, TWSR_SEL_REL, 1'b1, 1'b1, v);
    chk(v, {REL0, 7'h00});
    al(1'b0);
    // Wrong fixed bits, then wrong strap bits: no acknowledge.
    for (int i = 0; i < 2; i++) begin
      m.start();
      m.wbyte({i[0] ? TWSR_ADDR_HI : 4'h8, i[0] ? 3'h4 : 3'h5, 1'b0}, a);
      m.stop();
      chk({15'h0000, a}, 16'h0000);
    end
    // Limits round trip; an odd release limit needs the second byte's top bit.
    wr(TWSR_SEL_TRIP, 2, {TRIP1, 7'h7f});
    rd(1'b1, TWSR_SEL_TRIP, 1'b1, 1'b1, v);
    chk(v, {TRIP1, 7'h00});
    wr(TWSR_SEL_REL, 2, {REL1, 7'h00});
    rd(1'b1, TWSR_SEL_REL, 1'b1, 1'b1, v);
    chk(v, {REL1, 7'h00});
    wr(TWSR_SEL_TEMP, 2, 16'hffff);
    rd(1'b0, 2'h0, 1'b1, 1'b1, v);
    chk(v, {ROOM, 7'h00});
    // Every queue depth, with a restart by one good reading.
    for (int q = 0; q < 4; q++) begin
      n = (q == 3) ? 6 : (1 << q);
      wr(TWSR_SEL_CFG, 1, {3'h0, q[1:0], 3'h0, 8'h00});
      feed(HOT, n - 1);
      al(1'b0);
      feed(MID, 1);
      feed(HOT, n - 1);
      al(1'b0);
      feed(HOT, 1);
      al(1'b1);
      feed(COLD, n);
      al(1'b0);
    end
    rd(1'b1, TWSR_SEL_TEMP, 1'b1, 1'b1, v);
    chk(v, {COLD, 7'h00});
    // Active-high polarity inverts the pin.
    wr(TWSR_SEL_CFG, 1, 16'h0400);
    al(1'b1);
    feed(HOT, 1);
    al(1'b0);
    feed(COLD, 1);
    // Latched alarm, cleared by a read or by shutdown.
    wr(TWSR_SEL_CFG, 1, 16'h0200);
    feed(HOT, 1);
    al(1'b1);
    feed(HOT, 1);
    al(1'b1);
    rd(1'b1, TWSR_SEL_TEMP, 1'b1, 1'b1, v);
    chk(v, {HOT, 7'h00});
    al(1'b0);
    feed(HOT, 1);
    al(1'b0);
    feed(COLD, 1);
    al(1'b1);
    wr(TWSR_SEL_CFG, 1, 16'h0300);
    al(1'b0);
    chk({15'h0000, shut}, 16'h0001);
    feed(HOT, 1);
    rd(1'b1, TWSR_SEL_TEMP, 1'b1, 1'b1, v);
    chk(v, {COLD, 7'h00});
    rd(1'b1, TWSR_SEL_CFG, 1'b0, 1'b1, v);
    chk(v, 16'h0300);
    wr(TWSR_SEL_CFG, 1, 16'h0000);
    chk({15'h0000, shut}, 16'h0000);
    // Short read and acked final byte leave the line low until recovery.
    rd(1'b1, TWSR_SEL_TRIP, 1'b0, 1'b0, v);
    chk(v, {TRIP1[8:1], 8'h00});
    rd(1'b0, 2'h0, 1'b1, 1'b0, v);
    chk(v, {TRIP1, 7'h00});
    close_out();
  end
endmodule
